// *** design/occ_clock_control.sv ***
// Clock control unit: four APB registers, switch and divider outputs.
// Assumes oscillator inputs are asynchronous to pclk.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module occ_clock_control
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] initial_source_config,
    input wire logic [1:0] primary_submode_config,
    input wire logic [1:0] switch_and_monitor_config,
    input wire logic pll_locked_raw,
    input wire logic src_ready_raw,
    input wire logic new_clk_tick_raw,
    input wire logic fail_detect_raw,
    input wire logic interrupt_req,
    output logic [2:0] active_source,
    output logic [1:0] primary_submode,
    output logic [5:0] pll_prescale_div,
    output logic [9:0] pll_multiplier,
    output logic [3:0] pll_postscale_div,
    output logic [8:0] fast_rc_postscale_div,
    output logic [5:0] fast_rc_trim_field,
    output logic [7:0] cpu_clock_ratio,
    output logic secondary_osc_on,
    output logic pin_select_write_allow,
    output logic instr_clk_en
);
    // ****************************************
    // Synchronisers
    // ****************************************
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic tick_prev_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            tick_prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= {fail_detect_raw, new_clk_tick_raw,
                src_ready_raw, pll_locked_raw};
            sync2_ff <= sync1_ff;
            tick_prev_ff <= sync2_ff[2];
        end
    end
    logic pll_lock_s;
    logic src_ready_s;
    logic new_tick;
    logic fail_s;
    assign pll_lock_s = sync2_ff[0];
    assign src_ready_s = sync2_ff[1];
    assign new_tick = sync2_ff[2] & ~tick_prev_ff;
    assign fail_s = sync2_ff[3];

    // ****************************************
    // APB decode
    // ****************************************
    logic wr_en;
    logic rd_en;
    logic hit;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    always_comb
    begin
        if (paddr == occ_pkg::OCC_OSC_CTRL_ADDR)
            hit = 1'b1;
        else if (paddr == occ_pkg::OCC_CLK_DIV_ADDR)
            hit = 1'b1;
        else if (paddr == occ_pkg::OCC_PLL_FBD_ADDR)
            hit = 1'b1;
        else if (paddr == occ_pkg::OCC_TRIM_ADDR)
            hit = 1'b1;
        else if (paddr == occ_pkg::OCC_UNLOCK_ADDR)
            hit = 1'b1;
        else
            hit = 1'b0;
    end
    assign pslverr = psel & penable & ~hit;

    logic wr_osc;
    logic wr_div;
    logic wr_fbd;
    logic wr_trim;
    logic wr_key;
    assign wr_osc = wr_en & (paddr == occ_pkg::OCC_OSC_CTRL_ADDR);
    assign wr_div = wr_en & (paddr == occ_pkg::OCC_CLK_DIV_ADDR);
    assign wr_fbd = wr_en & (paddr == occ_pkg::OCC_PLL_FBD_ADDR);
    assign wr_trim = wr_en & (paddr == occ_pkg::OCC_TRIM_ADDR);
    assign wr_key = wr_en & (paddr == occ_pkg::OCC_UNLOCK_ADDR);

    // ****************************************
    // Unlock sequence
    // ****************************************
    // Any other access drops the arm, so stray writes cannot slip in
    logic key1_ff;
    logic unlock_ff;
    logic osc_hi_wr;
    logic osc_lo_wr;
    assign osc_hi_wr = wr_osc & pstrb[1] & unlock_ff;
    assign osc_lo_wr = wr_osc & pstrb[0] & unlock_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key1_ff <= 1'b0;
            unlock_ff <= 1'b0;
        end
        else if (psel & penable)
        begin
            key1_ff <= wr_key & (pwdata[15:0] == occ_pkg::OCC_UNLOCK_KEY1);
            unlock_ff <= wr_key & key1_ff &
                (pwdata[15:0] == occ_pkg::OCC_UNLOCK_KEY2);
        end
    end

    // ****************************************
    // Power-on strap capture
    // ****************************************
    // Straps load one edge after release
    logic strap_done_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            strap_done_ff <= 1'b0;
        else
            strap_done_ff <= 1'b1;
    end
    logic strap_load;
    assign strap_load = ~strap_done_ff;

    // ****************************************
    // Oscillator control register
    // ****************************************
    logic [2:0] cur_src_ff;
    logic [2:0] new_src_ff;
    logic clk_lock_ff;
    logic pin_lock_ff;
    logic fail_ff;
    logic sec_en_ff;
    logic sw_req_ff;
    logic [1:0] submode_ff;
    logic sw_enabled;
    logic sw_locked;
    logic sw_go;
    occ_sw_if sw ();

    assign sw_enabled = ~switch_and_monitor_config[1];
    assign sw_locked = clk_lock_ff &
        (switch_and_monitor_config == occ_pkg::OCC_SWMON_SW_ONLY);
    assign sw_go = sw_req_ff & ~sw.busy & ~sw_locked & ~strap_load;
    assign sw.start = sw_go & (new_src_ff != cur_src_ff);
    assign sw.target = new_src_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_src_ff <= 3'h0;
            new_src_ff <= 3'h0;
            submode_ff <= 2'h0;
        end
        else if (strap_load)
        begin
            cur_src_ff <= initial_source_config;
            new_src_ff <= initial_source_config;
            submode_ff <= primary_submode_config;
        end
        else
        begin
            if (osc_hi_wr)
                new_src_ff <= pwdata[occ_pkg::OCC_NEW_SRC_LSB +: 3];
            if (sw.done)
                cur_src_ff <= new_src_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clk_lock_ff <= 1'b0;
            pin_lock_ff <= 1'b0;
            sec_en_ff <= 1'b0;
        end
        else if (osc_lo_wr)
        begin
            clk_lock_ff <= pwdata[occ_pkg::OCC_CLK_LOCK_BIT];
            pin_lock_ff <= pwdata[occ_pkg::OCC_PIN_LOCK_BIT];
            sec_en_ff <= pwdata[occ_pkg::OCC_SEC_EN_BIT];
        end
    end

    // Held at zero while switching is disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sw_req_ff <= 1'b0;
        else if (!sw_enabled || sw.done || (sw_go && !sw.start))
            sw_req_ff <= 1'b0;
        else if (osc_lo_wr && pwdata[occ_pkg::OCC_SW_REQ_BIT])
            sw_req_ff <= 1'b1;
    end

    // Set wins over clear; a valid start clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fail_ff <= 1'b0;
        else if (fail_s)
            fail_ff <= 1'b1;
        else if (sw.start || (osc_lo_wr && !pwdata[occ_pkg::OCC_FAIL_BIT]))
            fail_ff <= 1'b0;
    end

    occ_switch_seq u_seq
    (
        .pclk(pclk),
        .presetn(presetn),
        .src_ready(src_ready_s),
        .src_tick(new_tick),
        .sw(sw)
    );

    // ****************************************
    // Divisor, feedback and trim registers
    // ****************************************
    logic [15:0] div_ff;
    logic [8:0] fbd_ff;
    logic [5:0] trim_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_ff <= occ_pkg::OCC_CLK_DIV_RST;
        else if (wr_div)
        begin
            if (pstrb[1])
                div_ff[15:8] <= pwdata[15:8];
            if (pstrb[0])
                div_ff[7:0] <= pwdata[7:0] & 8'hDF;
        end
        else if (interrupt_req && div_ff[occ_pkg::OCC_RECOVER_BIT])
            div_ff[occ_pkg::OCC_DOZE_EN_BIT] <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fbd_ff <= occ_pkg::OCC_PLL_FBD_RST;
        else if (wr_fbd)
        begin
            if (pstrb[1])
                fbd_ff[8] <= pwdata[8];
            if (pstrb[0])
                fbd_ff[7:0] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trim_ff <= 6'h00;
        else if (wr_trim && pstrb[0])
            trim_ff <= pwdata[5:0];
    end

    // ****************************************
    // Derived settings
    // ****************************************
    logic [1:0] post_code;
    logic [2:0] doze_code;
    logic [2:0] rc_code;
    assign post_code = div_ff[occ_pkg::OCC_POST_LSB +: 2];
    assign doze_code = div_ff[occ_pkg::OCC_DOZE_LSB +: 3];
    assign rc_code = div_ff[occ_pkg::OCC_RCDIV_LSB +: 3];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_prescale_div <= 6'h02;
            pll_multiplier <= 10'h032;
            pll_postscale_div <= 4'h4;
            fast_rc_postscale_div <= 9'h001;
            cpu_clock_ratio <= 8'h01;
        end
        else
        begin
            // Factor M over N1*N2 is realised by the analog PLL
            pll_prescale_div <= {1'b0, div_ff[4:0]} + 6'h02;
            pll_multiplier <= {1'b0, fbd_ff} + 10'h002;
            case (post_code)
                2'h0: pll_postscale_div <= 4'h2;
                2'h1: pll_postscale_div <= 4'h4;
                2'h3: pll_postscale_div <= 4'h8;
                default: pll_postscale_div <= 4'h0; // Reserved code
            endcase
            if (rc_code == 3'h7)
                fast_rc_postscale_div <= 9'h100;
            else
                fast_rc_postscale_div <= 9'h001 << rc_code;
            if (div_ff[occ_pkg::OCC_DOZE_EN_BIT])
                cpu_clock_ratio <= 8'h01 << doze_code;
            else
                cpu_clock_ratio <= 8'h01;
        end
    end

    // Enable on every second pclk
    logic half_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            half_ff <= 1'b0;
        else
            half_ff <= ~half_ff;
    end
    assign instr_clk_en = half_ff;

    assign active_source = cur_src_ff;
    assign primary_submode = submode_ff;
    assign fast_rc_trim_field = trim_ff;
    assign secondary_osc_on = sec_en_ff;
    assign pin_select_write_allow = ~pin_lock_ff;

    // ****************************************
    // Read data
    // ****************************************
    logic [15:0] osc_rd;
    assign osc_rd = {1'b0, cur_src_ff, 1'b0, new_src_ff, clk_lock_ff,
        pin_lock_ff, pll_lock_s, 1'b0, fail_ff, 1'b0, sec_en_ff,
        sw_req_ff};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == occ_pkg::OCC_OSC_CTRL_ADDR)
                prdata <= {16'h0000, osc_rd};
            else if (paddr == occ_pkg::OCC_CLK_DIV_ADDR)
                prdata <= {16'h0000, div_ff & occ_pkg::OCC_CLK_DIV_MASK};
            else if (paddr == occ_pkg::OCC_PLL_FBD_ADDR)
                prdata <= {23'h000000, fbd_ff};
            else if (paddr == occ_pkg::OCC_TRIM_ADDR)
                prdata <= {26'h0000000, trim_ff};
            else
                prdata <= 32'h0000_0000;
        end
    end
endmodule

// *** design/occ_pkg.sv ***
// Constants, register map and encodings of the clock control block.
// Assumes an APB slave with 32-bit data; registers are 16 bits wide.
// Functional notes
// - Prescale is field plus two.
// - Multiplier is field plus two.
// - Postscale 00=2, 01=4, 11=8.
// - Output is input times M/(N1*N2).
// - Three-bit source code, eight sources.
// - Primary submode from strap field.
// - Erased device starts on divided RC.
// - New source loads from straps.
// - Clock lock freezes source when 01.
// - Pin lock blocks pin-select writes.
// - Read-only PLL lock flag.
// - Monitor sets fail flag; software clears.
// - Enable bit switches secondary oscillator.
// - Request bit reads zero when done.
// - Interrupt may clear doze enable.
// - Doze ratio is two to field.
// - Doze enable clear forces 1:1.
// - RC postscale 2^n, code 111 is 256.
// - Six-bit two's-complement RC trim.
// - Instruction clock is output over two.
// - Unlock before each control byte write.
// - Await ready, ten cycles, then switch.
// - Unimplemented bits read zero.

package occ_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OCC_OSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] OCC_CLK_DIV_ADDR = 8'h04;
    localparam logic [7:0] OCC_PLL_FBD_ADDR = 8'h08;
    localparam logic [7:0] OCC_TRIM_ADDR = 8'h0C;
    localparam logic [7:0] OCC_UNLOCK_ADDR = 8'h10;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int OCC_CUR_SRC_LSB = 12;
    localparam int OCC_NEW_SRC_LSB = 8;
    localparam int OCC_CLK_LOCK_BIT = 7;
    localparam int OCC_PIN_LOCK_BIT = 6;
    localparam int OCC_PLL_LOCK_BIT = 5;
    localparam int OCC_FAIL_BIT = 3;
    localparam int OCC_SEC_EN_BIT = 1;
    localparam int OCC_SW_REQ_BIT = 0;
    localparam int OCC_RECOVER_BIT = 15;
    localparam int OCC_DOZE_LSB = 12;
    localparam int OCC_DOZE_EN_BIT = 11;
    localparam int OCC_RCDIV_LSB = 8;
    localparam int OCC_POST_LSB = 6;
    localparam int OCC_PRE_LSB = 0;
    localparam logic [15:0] OCC_CLK_DIV_RST = 16'h3040;
    localparam logic [15:0] OCC_CLK_DIV_MASK = 16'hFFDF;
    localparam logic [8:0] OCC_PLL_FBD_RST = 9'h030;
    localparam logic [15:0] OCC_UNLOCK_KEY1 = 16'h0057;
    localparam logic [15:0] OCC_UNLOCK_KEY2 = 16'h00AA;
    localparam logic [1:0] OCC_SWMON_SW_ONLY = 2'h1;
    localparam logic [1:0] OCC_POST_RESERVED = 2'h2;
    localparam logic [3:0] OCC_SWITCH_WAIT = 4'hA;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [2:0] {
        OCC_SRC_RC = 3'h0,
        OCC_SRC_RC_PLL = 3'h1,
        OCC_SRC_PRI = 3'h2,
        OCC_SRC_PRI_PLL = 3'h3,
        OCC_SRC_SEC = 3'h4,
        OCC_SRC_LP_RC = 3'h5,
        OCC_SRC_RC_DIV16 = 3'h6,
        OCC_SRC_RC_DIVN = 3'h7
    } occ_src_type;

    typedef enum logic [1:0] {
        OCC_PRI_EXT = 2'h0,
        OCC_PRI_XTAL = 2'h1,
        OCC_PRI_FAST_XTAL = 2'h2,
        OCC_PRI_OFF = 2'h3
    } occ_pri_type;
endpackage

// *** design/occ_sw_if.sv ***
// Handshake between the register file and the switch sequencer.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface occ_sw_if;
    logic start;
    logic [2:0] target;
    logic busy;
    logic done;
    modport ctrl (output start, output target, input busy, input done);
    modport seq (input start, input target, output busy, output done);
endinterface

// *** design/occ_switch_seq.sv ***
// Clock switch sequencer: awaits the new source, counts its cycles.
// Assumes synchronised inputs.
`timescale 1ns/1ps
module occ_switch_seq
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_ready,
    input wire logic src_tick,
    occ_sw_if.seq sw
);
    typedef enum logic [1:0] {OCC_IDLE, OCC_WAIT_RDY, OCC_COUNT,
        OCC_DONE} occ_seq_type;
    occ_seq_type state_ff;
    logic [3:0] cnt_ff;

    // ****************************************
    // Sequence
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= OCC_IDLE;
            cnt_ff <= 4'h0;
        end
        else
        begin
            case (state_ff)
                OCC_IDLE:
                begin
                    cnt_ff <= 4'h0;
                    if (sw.start)
                        state_ff <= OCC_WAIT_RDY;
                end
                OCC_WAIT_RDY:
                    if (src_ready)
                        state_ff <= OCC_COUNT;
                OCC_COUNT:
                    if (src_tick)
                    begin
                        if (cnt_ff == occ_pkg::OCC_SWITCH_WAIT - 4'h1)
                            state_ff <= OCC_DONE;
                        cnt_ff <= cnt_ff + 4'h1;
                    end
                default:
                    state_ff <= OCC_IDLE;
            endcase
        end
    end

    assign sw.busy = (state_ff != OCC_IDLE);
    assign sw.done = (state_ff == OCC_DONE);
endmodule

// *** tb/occ_clock_control_checker.sv ***
// Port-level assertions of the clock control block.
// Assumes one pclk domain.
`timescale 1ns/1ps
module occ_clock_control_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic interrupt_req,
    input wire logic [5:0] pll_prescale_div,
    input wire logic [9:0] pll_multiplier,
    input wire logic [3:0] pll_postscale_div,
    input wire logic [8:0] fast_rc_postscale_div,
    input wire logic [5:0] fast_rc_trim_field,
    input wire logic [7:0] cpu_clock_ratio,
    input wire logic instr_clk_en
);
    // ****************************************
    // Decoded accesses
    // ****************************************
    logic acc;
    logic wr_div;
    logic wr_fbd;
    logic wr_trim;
    assign acc = psel && penable;
    assign wr_div = acc && pwrite && paddr == occ_pkg::OCC_CLK_DIV_ADDR;
    assign wr_fbd = acc && pwrite && paddr == occ_pkg::OCC_PLL_FBD_ADDR;
    assign wr_trim = acc && pwrite && paddr == occ_pkg::OCC_TRIM_ADDR;

    function automatic logic [3:0] post_of(input logic [1:0] c);
        post_of = c[1] ? (c[0] ? 4'h8 : 4'h0) : (c[0] ? 4'h4 : 4'h2);
    endfunction

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************************************
    // Assertions
    // ****************************************
    // Divider and feedback outputs land two edges after the write; the trim output lands after one
    a_prescale_map: assert property (
        wr_div && pstrb[0] |-> ##2
        pll_prescale_div == {1'b0, $past(pwdata[4:0], 2)} + 6'h02)
        else $error("prescale wrong");
    a_multiplier_map: assert property (
        wr_fbd && pstrb[1:0] == 2'h3 |-> ##2
        pll_multiplier == {1'b0, $past(pwdata[8:0], 2)} + 10'h002)
        else $error("multiplier wrong");
    a_postscale_map: assert property (
        wr_div && pstrb[0] |-> ##2
        pll_postscale_div == post_of($past(pwdata[7:6], 2)))
        else $error("postscale wrong");
    a_rc_post_map: assert property (
        wr_div && pstrb[1] |-> ##2 fast_rc_postscale_div ==
        ($past(pwdata[10:8], 2) == 3'h7 ? 9'h100 :
        9'h001 << $past(pwdata[10:8], 2)))
        else $error("rc postscale wrong");
    a_doze_ratio: assert property (
        (wr_div && pstrb[1] && !interrupt_req) ##1 !interrupt_req |-> ##1
        cpu_clock_ratio == ($past(pwdata[11], 2) ?
        8'h01 << $past(pwdata[14:12], 2) : 8'h01))
        else $error("cpu ratio wrong");
    a_trim_map: assert property (
        wr_trim && pstrb[0] |-> ##2 fast_rc_trim_field == $past(pwdata[5:0], 2))
        else $error("trim wrong");
    a_zero_wait: assert property (
        acc |-> pready)
        else $error("no ready in access");
    a_unmapped_err: assert property (
        acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h10))
        else $error("error response wrong");
    a_upper_zero: assert property (
        acc && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read data set");
    a_instr_toggle: assert property (
        $past(presetn) |-> instr_clk_en != $past(instr_clk_en))
        else $error("enable did not alternate");
endmodule

bind occ_clock_control occ_clock_control_checker u_checker
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .interrupt_req, .pll_prescale_div,
    .pll_multiplier, .pll_postscale_div, .fast_rc_postscale_div,
    .fast_rc_trim_field, .cpu_clock_ratio, .instr_clk_en
);

// *** tb/occ_clock_control_tb.sv ***
// Self-checking APB bench of the clock control block.
// Assumes the bound checker; raw inputs are levels.
`timescale 1ns/1ps
module occ_clock_control_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, cpu_clock_ratio;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, pll_postscale_div;
    logic [2:0] initial_source_config, active_source;
    logic [1:0] primary_submode_config, switch_and_monitor_config;
    logic [1:0] primary_submode;
    logic pll_locked_raw, src_ready_raw, new_clk_tick_raw;
    logic fail_detect_raw, interrupt_req, secondary_osc_on, err_seen;
    logic pin_select_write_allow, instr_clk_en;
    logic [5:0] pll_prescale_div, fast_rc_trim_field;
    logic [9:0] pll_multiplier;
    logic [8:0] fast_rc_postscale_div;
    int mismatches, checked, n;
    logic [23:0] corners [9] = '{24'h04_0000, 24'h04_FFFF, 24'h04_001F,
        24'h04_0080, 24'h08_FFFF, 24'h08_0000, 24'h08_001E, 24'h0C_001F,
        24'h0C_0020};
    localparam logic [7:0] OSC = occ_pkg::OCC_OSC_CTRL_ADDR;
    localparam logic [7:0] DIV = occ_pkg::OCC_CLK_DIV_ADDR;

    occ_clock_control u_dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .initial_source_config,
        .primary_submode_config, .switch_and_monitor_config,
        .pll_locked_raw, .src_ready_raw, .new_clk_tick_raw,
        .fail_detect_raw, .interrupt_req, .active_source, .primary_submode,
        .pll_prescale_div, .pll_multiplier, .pll_postscale_div,
        .fast_rc_postscale_div, .fast_rc_trim_field, .cpu_clock_ratio,
        .secondary_osc_on, .pin_select_write_allow, .instr_clk_en
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits on pready, gives up after 50 cycles
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            mismatches++;
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic get(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 4'hF);
    endtask

    // One key pair per control byte write
    task automatic osc_wr(input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, occ_pkg::OCC_UNLOCK_ADDR, 32'h0000_0057, 4'hF);
        apb(1'b1, occ_pkg::OCC_UNLOCK_ADDR, 32'h0000_00AA, 4'hF);
        apb(1'b1, OSC, d, s);
        get(OSC);
    endtask

    task automatic ticks(input int k);
        repeat (k)
        begin
            repeat (2) @(posedge pclk);
            new_clk_tick_raw <= 1'b1;
            repeat (4) @(posedge pclk);
            new_clk_tick_raw <= 1'b0;
        end
    endtask

    function automatic logic [3:0] post_exp(input logic [1:0] c);
        post_exp = c[1] ? (c[0] ? 4'h8 : 4'h0) : (c[0] ? 4'h4 : 4'h2);
    endfunction

    task automatic reg_case(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0, d}, 4'hF);
        get(a);
        if (a == DIV)
        begin
            check("div read", rd, 32'(d & 16'hFFDF));
            check("prescale", 32'(pll_prescale_div), 32'(d[4:0]) + 2);
            check("postscale", 32'(pll_postscale_div), 32'(post_exp(d[7:6])));
            check("rc div", 32'(fast_rc_postscale_div),
                d[10:8] == 3'h7 ? 32'h100 : 32'h1 << d[10:8]);
            check("ratio", 32'(cpu_clock_ratio),
                d[11] ? 32'h1 << d[14:12] : 32'h1);
        end
        else if (a == occ_pkg::OCC_PLL_FBD_ADDR)
        begin
            check("fbd read", rd, 32'(d & 16'h01FF));
            check("multiplier", 32'(pll_multiplier), 32'(d[8:0]) + 2);
        end
        else
        begin
            check("trim read", rd, 32'(d & 16'h003F));
            check("trim", 32'(fast_rc_trim_field), 32'(d[5:0]));
        end
    endtask

    task automatic do_reset(input logic [2:0] src);
        presetn <= 1'b0;
        initial_source_config <= src;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check("source", 32'(active_source), 32'(src));
        check("submode", 32'(primary_submode), 32'h2);
        check("sec on", 32'(secondary_osc_on), 32'h0);
        get(OSC);
        check("osc read", rd, 32'({1'b0, src, 1'b0, src, 8'h20}));
        reg_case(DIV, 16'h3040);
    endtask

    // ****************************************
    // Clock, watchdog and main sequence
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    initial
    begin
        #(25 * 80000);
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        presetn = 1'b0;
        initial_source_config = 3'h7;
        primary_submode_config = 2'h2;
        switch_and_monitor_config = 2'h1;
        pll_locked_raw = 1'b1;
        {src_ready_raw, new_clk_tick_raw, fail_detect_raw} = 3'h0;
        interrupt_req = 1'b0;
        mismatches = 0;
        checked = 0;
        void'($urandom(32'hF1222295));
        do_reset(3'h7);
        foreach (corners[i])
            reg_case(corners[i][23:16], corners[i][15:0]);
        repeat (24)
            reg_case(8'(4 + 4 * $urandom_range(0, 2)), 16'($urandom()));
        get(8'h14);
        check("unmapped read", rd, 32'h0);
        check("unmapped err", 32'(err_seen), 32'h1);
        reg_case(DIV, 16'h3040);
        apb(1'b1, DIV, 32'h0000_FF1F, 4'h1);
        reg_case(DIV, 16'hB840);
        @(posedge pclk);
        interrupt_req <= 1'b1;
        @(posedge pclk);
        interrupt_req <= 1'b0;
        get(DIV);
        check("recover clear", rd, 32'h0000_B040);
        check("recover ratio", 32'(cpu_clock_ratio), 32'h1);
        reg_case(DIV, 16'h3840);
        interrupt_req <= 1'b1;
        @(posedge pclk);
        interrupt_req <= 1'b0;
        get(DIV);
        check("no recover", 32'(cpu_clock_ratio), 32'h8);
        apb(1'b1, OSC, 32'h0000_0002, 4'h1);
        get(OSC);
        check("locked write", 32'(secondary_osc_on), 32'h0);
        osc_wr(32'h0000_0002, 4'h1);
        check("sec on", 32'(secondary_osc_on), 32'h1);
        fail_detect_raw <= 1'b1;
        repeat (4) @(posedge pclk);
        fail_detect_raw <= 1'b0;
        get(OSC);
        check("fail set", 32'(rd[3]), 32'h1);
        osc_wr(32'h0000_0042, 4'h1);
        check("fail clear", 32'(rd[3]), 32'h0);
        check("pin lock", 32'(pin_select_write_allow), 32'h0);
        osc_wr(32'h0000_0002, 4'h1);
        check("pin open", 32'(pin_select_write_allow), 32'h1);
        osc_wr(32'h0000_0100, 4'h2);
        osc_wr(32'h0000_0003, 4'h1);
        src_ready_raw <= 1'b1;
        ticks(9);
        check("early switch", 32'(active_source), 32'h7);
        n = 9;
        while (active_source === 3'h7 && n < 20)
        begin
            ticks(1);
            n++;
        end
        check("tick count", 32'(n >= 10 && n <= 11), 32'h1);
        get(OSC);
        check("switched", 32'(rd[14:12]), 32'h1);
        check("request done", 32'(rd[0]), 32'h0);
        osc_wr(32'h0000_0082, 4'h1);
        osc_wr(32'h0000_0000, 4'h2);
        osc_wr(32'h0000_0083, 4'h1);
        ticks(15);
        check("frozen", 32'(active_source), 32'h1);
        do_reset(3'h4);
        report_and_stop();
    end
endmodule
